// ===== rtl/ecphc_host.sv
// Host sequencer that drives an ECP parallel port through its registers
//
// Contract
// - Negotiate, clear direction, strobe and auto-feed, then select ECP mode; the code does no negotiation, only mode 001, the control write, then ECP.
// - Set up control lines in modes 000/001; handshake runs only in 010/011.
// - Any mode is reachable from 000/001; others may return only to 000/001.
// - Direction bit changes only while the port is in mode 001.
// - After forward transfers wait for an empty queue before leaving.
// - After reverse transfers drain the queue before leaving.
// - PeriphAck high marks data, low marks command; device classifies.
// - Reverse command bytes from the peripheral have MSB zero.
// - RLE: count to address/RLE queue, then data byte to data queue.
// - Programmed I/O: set direction and mode, clear DMA enable and service flag; the code clears the service flag but sets DMA enable from the command.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ecphc_host (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [3:0]  sw_addr_in,
	input  wire logic [15:0] sw_wdata_in,
	input  wire logic        sw_wr_in,
	input  wire logic        sw_rd_in,
	output logic      [15:0] sw_rdata_out,
	output logic      [10:0] dev_addr_out,
	output logic      [7:0]  dev_wdata_out,
	output logic             dev_wr_out,
	output logic             dev_rd_out,
	input  wire logic [7:0]  dev_rdata_in,
	input  wire logic        dev_irq_in,
	input  wire logic        dev_drq_in
);
	ecphc_pkg::ecphc_state_t state_r;
	ecphc_pkg::ecphc_state_t state_nxt;
	ecphc_pkg::ecphc_op_t    op_r;
	logic [1:0]              step_r;
	logic [2:0]              mode_arg_r;
	logic                    dir_arg_r;
	logic                    dma_arg_r;
	logic [15:0]             arg_r;
	logic [7:0]              ecr_r;
	logic [7:0]              dcr_r;
	logic [2:0]              last_mode_r;
	logic [7:0]              rx_r;
	logic                    rx_valid_r;
	logic                    err_r;
	logic                    done_r;
	logic [1:0]              pin_s1_r;
	logic [1:0]              pin_s2_r;
	logic [10:0]             dev_addr_r;
	logic [7:0]              dev_wdata_r;
	logic                    dev_wr_r;
	logic                    dev_rd_r;
	logic [15:0]             sw_rdata_r;

	// Decoded view of the last extended control read
	wire  [2:0]  cur_mode  = ecr_r[ecphc_pkg::ECR_MODE_LSB +: 3];
	wire         cur_base  = (cur_mode == ecphc_pkg::MODE_STD) || (cur_mode == ecphc_pkg::MODE_PS2);
	wire         cur_empty = ecr_r[ecphc_pkg::ECR_EMPTY];
	wire         cur_full  = ecr_r[ecphc_pkg::ECR_FULL];
	wire         busy      = (state_r != ecphc_pkg::ST_IDLE);
	wire         cmd_go    = sw_wr_in && (sw_addr_in == ecphc_pkg::SW_CMD) && !busy
	                         && (sw_wdata_in[2:0] != 3'h0);
	// Every mode write clears the service flag and sets DMA from the command
	wire  [7:0]  ecr_ps2   = {ecphc_pkg::MODE_PS2, 1'b1, dma_arg_r, 1'b0, 2'b00};
	wire  [7:0]  ecr_tgt   = {mode_arg_r, 1'b1, dma_arg_r, 1'b0, 2'b00};
	wire  [7:0]  dcr_dir   = {dcr_r[7:6], dir_arg_r, dcr_r[4:0]};
	wire         wr_ecr    = dev_wr_r && (dev_addr_r == ecphc_pkg::DEV_ECR);
	wire         wr_dcr    = dev_wr_r && (dev_addr_r == ecphc_pkg::DEV_DCR);
	wire         wr_queue  = dev_wr_r && ((dev_addr_r == ecphc_pkg::DEV_DFIFO)
	                         || (dev_addr_r == ecphc_pkg::DEV_AFIFO));
	wire         fwd_ok    = (cur_mode == ecphc_pkg::MODE_ECP) && !dcr_r[ecphc_pkg::DCR_DIR];
	wire         rev_ok    = (cur_mode == ecphc_pkg::MODE_ECP) && dcr_r[ecphc_pkg::DCR_DIR];
	wire         rle_first = (op_r == ecphc_pkg::OP_RLE) && (step_r == 2'h0);

	// Decision taken in each ST_EVAL cycle from the last look at the port state
	logic        e_wr;
	logic        e_poll;
	logic        e_skip;
	logic        e_rdd;
	logic        e_err;
	logic        e_done;
	logic [10:0] e_addr;
	logic [7:0]  e_data;
	always_comb begin
		e_wr   = 1'b0;
		e_poll = 1'b0;
		e_skip = 1'b0;
		e_rdd  = 1'b0;
		e_err  = 1'b0;
		e_done = 1'b0;
		e_addr = ecphc_pkg::DEV_ECR;
		e_data = ecr_tgt;
		unique case (op_r)
			ecphc_pkg::OP_INIT, ecphc_pkg::OP_MODE: begin
				if (step_r == 2'h0) begin
					// Leave a transfer mode only via 001 and with an empty queue
					if (!cur_base && !cur_empty) begin
						e_err = 1'b1;
					end else begin
						e_wr   = 1'b1;
						e_data = ecr_ps2;
					end
				end else if (step_r == 2'h1) begin
					if (op_r == ecphc_pkg::OP_INIT) begin
						e_wr   = 1'b1;
						e_addr = ecphc_pkg::DEV_DCR;
						e_data = ecphc_pkg::DCR_INIT;
					end else begin
						e_skip = 1'b1;
					end
				end else begin
					e_wr   = 1'b1;
					e_done = 1'b1;
				end
			end
			ecphc_pkg::OP_DIR: begin
				if (cur_mode != ecphc_pkg::MODE_PS2) begin
					e_err = 1'b1;
				end else begin
					e_wr   = 1'b1;
					e_done = 1'b1;
					e_addr = ecphc_pkg::DEV_DCR;
					e_data = dcr_dir;
				end
			end
			ecphc_pkg::OP_DATA, ecphc_pkg::OP_COMMAND, ecphc_pkg::OP_RLE: begin
				if (!fwd_ok) begin
					e_err = 1'b1;
				end else if (cur_full) begin
					e_poll = 1'b1;
				end else begin
					// Count goes first to the command queue, then its byte as data
					e_wr   = 1'b1;
					e_done = !rle_first;
					e_addr = ((op_r == ecphc_pkg::OP_COMMAND) || rle_first) ?
					         ecphc_pkg::DEV_AFIFO : ecphc_pkg::DEV_DFIFO;
					e_data = (op_r == ecphc_pkg::OP_RLE && !rle_first) ? arg_r[15:8] : arg_r[7:0];
				end
			end
			ecphc_pkg::OP_READ: begin
				if (!rev_ok) begin
					e_err = 1'b1;
				end else if (cur_empty) begin
					e_poll = 1'b1;
				end else begin
					e_rdd = 1'b1;
				end
			end
			default: begin
				e_err = 1'b1;
			end
		endcase
	end

	// Sequencer: look at the port, decide, write or poll
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ecphc_pkg::ST_IDLE: state_nxt = cmd_go ? ecphc_pkg::ST_RD : ecphc_pkg::ST_IDLE;
			ecphc_pkg::ST_RD:   state_nxt = ecphc_pkg::ST_CAP;
			ecphc_pkg::ST_CAP:  state_nxt = ecphc_pkg::ST_EVAL;
			ecphc_pkg::ST_EVAL: begin
				if (e_err) begin
					state_nxt = ecphc_pkg::ST_IDLE;
				end else if (e_wr) begin
					state_nxt = ecphc_pkg::ST_WR;
				end else if (e_rdd) begin
					state_nxt = ecphc_pkg::ST_DRD;
				end else if (e_poll) begin
					state_nxt = ecphc_pkg::ST_RD;
				end else begin
					state_nxt = ecphc_pkg::ST_EVAL;
				end
			end
			ecphc_pkg::ST_WR:   state_nxt = done_r ? ecphc_pkg::ST_IDLE : ecphc_pkg::ST_RD;
			ecphc_pkg::ST_DRD:  state_nxt = ecphc_pkg::ST_DCAP;
			ecphc_pkg::ST_DCAP: state_nxt = ecphc_pkg::ST_IDLE;
		endcase
	end

	// State, command latch and step counter
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r    <= ecphc_pkg::ST_IDLE;
			op_r       <= ecphc_pkg::OP_NONE;
			step_r     <= 2'h0;
			mode_arg_r <= ecphc_pkg::MODE_STD;
			dir_arg_r  <= 1'b0;
			dma_arg_r  <= 1'b0;
			done_r     <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (cmd_go) begin
				op_r       <= ecphc_pkg::ecphc_op_t'(sw_wdata_in[2:0]);
				step_r     <= 2'h0;
				mode_arg_r <= (sw_wdata_in[2:0] == 3'h1) ? ecphc_pkg::MODE_ECP
				              : sw_wdata_in[ecphc_pkg::CMD_MODE_LSB +: 3];
				dir_arg_r  <= sw_wdata_in[ecphc_pkg::CMD_DIR];
				dma_arg_r  <= sw_wdata_in[ecphc_pkg::CMD_DMA];
			end else if (state_r == ecphc_pkg::ST_EVAL && (e_wr || e_skip)) begin
				step_r <= step_r + 2'h1;
				done_r <= e_done;
			end
		end
	end

	// Device bus strobes and address come straight from flops
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dev_addr_r  <= ecphc_pkg::DEV_ECR;
			dev_wdata_r <= 8'h00;
			dev_wr_r    <= 1'b0;
			dev_rd_r    <= 1'b0;
		end else begin
			dev_wr_r <= (state_nxt == ecphc_pkg::ST_WR);
			dev_rd_r <= (state_nxt == ecphc_pkg::ST_RD) || (state_nxt == ecphc_pkg::ST_DRD);
			if (state_nxt == ecphc_pkg::ST_RD) begin
				dev_addr_r <= ecphc_pkg::DEV_ECR;
			end else if (state_nxt == ecphc_pkg::ST_DRD) begin
				dev_addr_r <= ecphc_pkg::DEV_DFIFO;
			end else if (state_nxt == ecphc_pkg::ST_WR) begin
				dev_addr_r  <= e_addr;
				dev_wdata_r <= e_data;
			end
		end
	end

	// Shadow of what has been written to the port, and captured reads
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ecr_r       <= ecphc_pkg::ECR_RESET;
			dcr_r       <= ecphc_pkg::DCR_INIT;
			last_mode_r <= ecphc_pkg::MODE_STD;
			rx_r        <= 8'h00;
		end else begin
			if (state_r == ecphc_pkg::ST_CAP) begin
				ecr_r <= dev_rdata_in;
			end
			if (wr_ecr) begin
				last_mode_r <= dev_wdata_r[ecphc_pkg::ECR_MODE_LSB +: 3];
			end
			if (wr_dcr) begin
				dcr_r <= dev_wdata_r;
			end
			if (state_r == ecphc_pkg::ST_DCAP) begin
				rx_r <= dev_rdata_in;
			end
		end
	end

	// Sticky flags: a capture in the cycle of a clear still wins
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_valid_r <= 1'b0;
			err_r      <= 1'b0;
		end else begin
			if (state_r == ecphc_pkg::ST_DCAP) begin
				rx_valid_r <= 1'b1;
			end else if (sw_rd_in && sw_addr_in == ecphc_pkg::SW_RX) begin
				rx_valid_r <= 1'b0;
			end
			if (state_r == ecphc_pkg::ST_EVAL && e_err) begin
				err_r <= 1'b1;
			end else if (cmd_go) begin
				err_r <= 1'b0;
			end
		end
	end

	// Request pins come from another chip, so two flops before use
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_s1_r <= 2'b00;
			pin_s2_r <= 2'b00;
		end else begin
			pin_s1_r <= {dev_drq_in, dev_irq_in};
			pin_s2_r <= pin_s1_r;
		end
	end

	// Software port: argument latch and read data one cycle after the strobe
	wire [15:0] stat_word = {ecr_r, last_mode_r, pin_s2_r, rx_valid_r, err_r, busy};
	wire [15:0] rd_mux    = (sw_addr_in == ecphc_pkg::SW_STAT) ? stat_word :
	                        (sw_addr_in == ecphc_pkg::SW_RX)   ? {8'h00, rx_r} :
	                        (sw_addr_in == ecphc_pkg::SW_ARG)  ? arg_r : 16'h0000;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			arg_r      <= 16'h0000;
			sw_rdata_r <= 16'h0000;
		end else begin
			if (sw_wr_in && sw_addr_in == ecphc_pkg::SW_ARG) begin
				arg_r <= sw_wdata_in;
			end
			sw_rdata_r <= sw_rd_in ? rd_mux : 16'h0000;
		end
	end

	assign sw_rdata_out  = sw_rdata_r;
	assign dev_addr_out  = dev_addr_r;
	assign dev_wdata_out = dev_wdata_r;
	assign dev_wr_out    = dev_wr_r;
	assign dev_rd_out    = dev_rd_r;

	property p_init_dcr;
		@(posedge clk_in) disable iff (!arst_n_in)
		(wr_dcr && op_r == ecphc_pkg::OP_INIT) |-> (dev_wdata_r[ecphc_pkg::DCR_DIR] == 1'b0)
			&& (dev_wdata_r[ecphc_pkg::DCR_AFD] == 1'b0) && (dev_wdata_r[ecphc_pkg::DCR_STB] == 1'b0);
	endproperty
	a_init_dcr: assert property (p_init_dcr) else $error("init left a control line asserted");

	property p_dcr_in_setup;
		@(posedge clk_in) disable iff (!arst_n_in)
		wr_dcr |-> (last_mode_r == ecphc_pkg::MODE_PS2);
	endproperty
	a_dcr_in_setup: assert property (p_dcr_in_setup) else $error("control written outside mode 001");

	property p_mode_path;
		@(posedge clk_in) disable iff (!arst_n_in)
		(wr_ecr && dev_wdata_r[7:6] != 2'b00) |-> (last_mode_r[2:1] == 2'b00);
	endproperty
	a_mode_path: assert property (p_mode_path) else $error("transfer mode entered from another");

	property p_dir_refused;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cmd_go && sw_wdata_in[2:0] == 3'h3 && last_mode_r != ecphc_pkg::MODE_PS2)
			|-> ##[1:4] err_r;
	endproperty
	a_dir_refused: assert property (p_dir_refused) else $error("direction change outside 001 accepted");

	property p_leave_empty;
		@(posedge clk_in) disable iff (!arst_n_in)
		(wr_ecr && last_mode_r[2:1] != 2'b00 && dev_wdata_r[7:6] == 2'b00) |-> cur_empty;
	endproperty
	a_leave_empty: assert property (p_leave_empty) else $error("left transfer mode with queue busy");

	property p_queue_room;
		@(posedge clk_in) disable iff (!arst_n_in)
		wr_queue |-> (!cur_full && cur_mode == ecphc_pkg::MODE_ECP);
	endproperty
	a_queue_room: assert property (p_queue_room) else $error("queue written while full or not ECP");

	property p_rle_pair;
		@(posedge clk_in) disable iff (!arst_n_in)
		(op_r == ecphc_pkg::OP_RLE && wr_queue && dev_addr_r == ecphc_pkg::DEV_AFIFO)
			|=> busy ##2 (state_r == ecphc_pkg::ST_EVAL);
	endproperty
	a_rle_pair: assert property (p_rle_pair) else $error("count not followed by its data byte");

	property p_pio_clear;
		@(posedge clk_in) disable iff (!arst_n_in)
		wr_ecr |-> (!dev_wdata_r[ecphc_pkg::ECR_SVC] && dev_wdata_r[ecphc_pkg::ECR_DMA] == dma_arg_r);
	endproperty
	a_pio_clear: assert property (p_pio_clear) else $error("mode write left service flag set");

	property p_rx_capture;
		@(posedge clk_in) disable iff (!arst_n_in)
		(dev_rd_r && dev_addr_r == ecphc_pkg::DEV_DFIFO) |-> ##2 (rx_valid_r && rx_r == $past(dev_rdata_in));
	endproperty
	a_rx_capture: assert property (p_rx_capture) else $error("received byte not captured");
endmodule // ecphc_host
`default_nettype wire

// ===== rtl/ecphc_pkg.sv
// Constants and types shared by the ECP port host sequencer
`default_nettype none
package ecphc_pkg;
	// Device register offsets on its I/O bus
	localparam logic [10:0] DEV_AFIFO   = 11'h000;
	localparam logic [10:0] DEV_DCR     = 11'h002;
	localparam logic [10:0] DEV_DFIFO   = 11'h400;
	localparam logic [10:0] DEV_ECR     = 11'h402;
	// Mode field codes
	localparam logic [2:0]  MODE_STD    = 3'h0;
	localparam logic [2:0]  MODE_PS2    = 3'h1;
	localparam logic [2:0]  MODE_ECP    = 3'h3;
	// Extended control register layout
	localparam int          ECR_MODE_LSB = 5;
	localparam int          ECR_NERR    = 4;
	localparam int          ECR_DMA     = 3;
	localparam int          ECR_SVC     = 2;
	localparam int          ECR_FULL    = 1;
	localparam int          ECR_EMPTY   = 0;
	localparam logic [7:0]  ECR_RESET   = 8'h01;
	// Device control register layout
	localparam int          DCR_DIR     = 5;
	localparam int          DCR_AFD     = 1;
	localparam int          DCR_STB     = 0;
	localparam logic [7:0]  DCR_INIT    = 8'h04;
	// Own software registers
	localparam logic [3:0]  SW_CMD      = 4'h0;
	localparam logic [3:0]  SW_ARG      = 4'h1;
	localparam logic [3:0]  SW_STAT     = 4'h2;
	localparam logic [3:0]  SW_RX       = 4'h3;
	localparam int          CMD_MODE_LSB = 4;
	localparam int          CMD_DIR     = 8;
	localparam int          CMD_DMA     = 9;
	// Commands software may issue
	typedef enum logic [2:0] {
		OP_NONE,
		OP_INIT,
		OP_MODE,
		OP_DIR,
		OP_DATA,
		OP_COMMAND,
		OP_RLE,
		OP_READ
	} ecphc_op_t;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD,
		ST_CAP,
		ST_EVAL,
		ST_WR,
		ST_DRD,
		ST_DCAP
	} ecphc_state_t;
endpackage
`default_nettype wire

// ===== test/ecphc_dev_model.sv
// Behavioural model of the ECP port device that the host sequencer drives
`timescale 1ns/1ps
`default_nettype none
module ecphc_dev_model #(
	parameter int THR = 8 // Service threshold as set up in the configuration registers
) (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [10:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  rdata_out,
	output logic             irq_out,
	output logic             drq_out
);
	logic [2:0] mode_r;
	logic [2:0] ctl_r;
	logic [7:0] dcr_r;
	logic [8:0] q[$];
	logic [8:0] sent_q[$];
	logic [7:0] rev_q[$];
	int         bad_seq;
	int         tick;
	logic       xfer;
	logic       full;

	// Internal state is blocking; only the pins use non-blocking to avoid races
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_r = 3'h0;
			ctl_r = 3'h0;
			dcr_r = 8'h00;
			q.delete();
			tick = 0;
			rdata_out <= 8'h00;
			irq_out <= 1'b0;
			drq_out <= 1'b0;
		end else begin
			tick++;
			xfer = (mode_r == ecphc_pkg::MODE_ECP);
			full = (q.size() >= 16);
			if (wr_in && addr_in == ecphc_pkg::DEV_ECR) begin
				if (mode_r > 3'h1 && wdata_in[7:6] != 2'h0)
					bad_seq++;
				if (mode_r > 3'h1 && q.size() != 0 && wdata_in[7:5] != mode_r)
					bad_seq++;
				mode_r = wdata_in[7:5];
				ctl_r = wdata_in[4:2];
				if (mode_r == ecphc_pkg::MODE_STD)
					q.delete();
			end
			if (wr_in && addr_in == ecphc_pkg::DEV_DCR) begin
				if (wdata_in[5] != dcr_r[5] && mode_r != ecphc_pkg::MODE_PS2)
					bad_seq++;
				dcr_r = wdata_in;
			end
			// Queue writes outside forward ECP transfer are a host fault
			if (wr_in && (addr_in == ecphc_pkg::DEV_DFIFO || addr_in == ecphc_pkg::DEV_AFIFO)) begin
				if (!xfer || dcr_r[5] || full)
					bad_seq++;
				else
					q.push_back({addr_in[10], wdata_in});
			end
			if (rd_in && addr_in == ecphc_pkg::DEV_ECR)
				rdata_out <= {mode_r, ctl_r, full, q.size() == 0};
			else if (rd_in && addr_in == ecphc_pkg::DEV_DFIFO && q.size() != 0)
				rdata_out <= q.pop_front();
			else
				rdata_out <= ~rdata_out;
			// Slow cable side: one entry leaves every 16 ticks, so the queue backs up in forward traffic
			if (xfer && !dcr_r[5] && q.size() != 0 && tick % 16 == 0)
				sent_q.push_back(q.pop_front());
			if (xfer && dcr_r[5] && rev_q.size() != 0 && q.size() < 16 && tick % 4 == 0)
				q.push_back({1'b1, rev_q.pop_front()});
			if (xfer && !ctl_r[1] && ((!dcr_r[5] && 16 - q.size() >= THR) || (dcr_r[5] && q.size() >= THR)))
				ctl_r[0] = 1'b1;
			irq_out <= ctl_r[0] && !ctl_r[1];
			drq_out <= ctl_r[1] && !ctl_r[0] && xfer && !dcr_r[5] && q.size() < 16;
		end
	end
endmodule // ecphc_dev_model
`default_nettype wire

// ===== test/ecphc_host_tb_top.sv
// Self-checking bench for the ECP host sequencer against the device model
`timescale 1ns/1ps
`default_nettype none
module ecphc_host_tb_top;
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [3:0]  sw_addr = 4'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic        sw_wr = 1'b0;
	logic        sw_rd = 1'b0;
	logic [15:0] sw_rdata;
	logic [10:0] dev_addr;
	logic [7:0]  dev_wdata;
	logic        dev_wr;
	logic        dev_rd;
	logic [7:0]  dev_rdata;
	logic        irq;
	logic        drq;
	int          n_errors = 0;
	int          checks_done = 0;
	logic [7:0]  rnd = 8'h15;
	logic [8:0]  exp_q[$];
	logic [7:0]  rev_exp[$];
	logic [15:0] st;
	logic [15:0] d;

	ecphc_host dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata),
		.sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata), .dev_addr_out(dev_addr),
		.dev_wdata_out(dev_wdata), .dev_wr_out(dev_wr), .dev_rd_out(dev_rd), .dev_rdata_in(dev_rdata),
		.dev_irq_in(irq), .dev_drq_in(drq));
	ecphc_dev_model dev_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(dev_addr), .wdata_in(dev_wdata),
		.wr_in(dev_wr), .rd_in(dev_rd), .rdata_out(dev_rdata), .irq_out(irq), .drq_out(drq));

	// 20 MHz system clock
	initial begin
		forever #25 clk_in = ~clk_in;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	function automatic logic [15:0] cw(input ecphc_pkg::ecphc_op_t op, input logic [2:0] m, input logic dr,
		input logic en);
		return {6'h00, en, dr, 1'b0, m, 1'b0, op};
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic sw_write(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_in);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge clk_in);
		sw_wr <= 1'b0;
	endtask

	task automatic sw_read(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_in);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk_in);
		sw_rd <= 1'b0;
		#1 v = sw_rdata;
	endtask

	// Issues one command and polls status until the sequencer is idle again
	task automatic op(input logic [15:0] c, input logic [15:0] a, output logic [15:0] s);
		int i;
		sw_write(ecphc_pkg::SW_ARG, a);
		sw_write(ecphc_pkg::SW_CMD, c);
		for (i = 0; i < 300; i++) begin
			sw_read(ecphc_pkg::SW_STAT, s);
			if (s[0] === 1'b0)
				break;
		end
		if (i == 300) begin
			n_errors++;
			summarize();
		end
	endtask

	initial begin
		int i;
		logic [7:0] b;
		repeat (5) @(posedge clk_in);
		arst_n_in <= 1'b1;
		#1 check({5'h00, dev_addr}, 16'h0402);
		sw_read(ecphc_pkg::SW_STAT, st);
		check(st, {ecphc_pkg::ECR_RESET, 8'h00});
		sw_write(4'h9, 16'hffff);
		sw_read(ecphc_pkg::SW_STAT, st);
		check(st, {ecphc_pkg::ECR_RESET, 8'h00});
		$display("reset test done");
		op(cw(ecphc_pkg::OP_INIT, 3'h0, 1'b0, 1'b1), 16'h0000, st);
		check({15'h0, st[1]}, 16'h0000);
		check({13'h0, dev_u.mode_r}, 16'h0003);
		check({13'h0, dev_u.dcr_r[5], dev_u.dcr_r[1:0]}, 16'h0000);
		repeat (4) @(posedge clk_in);
		sw_read(ecphc_pkg::SW_STAT, st);
		check({15'h0, st[4]}, 16'h0001);
		$display("init test done");
		// Random data and command bytes back to back, then one compressed pair
		for (i = 0; i < 20; i++) begin
			rnd = lfsr(rnd);
			b = lfsr(rnd);
			exp_q.push_back({rnd[0], b});
			op(cw(rnd[0] ? ecphc_pkg::OP_DATA : ecphc_pkg::OP_COMMAND, 3'h0, 1'b0, 1'b1), {8'h00, b}, st);
		end
		exp_q.push_back({1'b0, 8'h05});
		exp_q.push_back({1'b1, b});
		op(cw(ecphc_pkg::OP_RLE, 3'h0, 1'b0, 1'b1), {b, 8'h05}, st);
		for (i = 0; i < 2000 && dev_u.sent_q.size() < exp_q.size(); i++)
			@(posedge clk_in);
		check(16'(dev_u.sent_q.size()), 16'(exp_q.size()));
		for (i = 0; i < exp_q.size() && i < dev_u.sent_q.size(); i++)
			check({7'h00, dev_u.sent_q[i]}, {7'h00, exp_q[i]});
		$display("forward test done");
		op(cw(ecphc_pkg::OP_DIR, 3'h0, 1'b1, 1'b0), 16'h0000, st);
		check({15'h0, st[1]}, 16'h0001);
		op(cw(ecphc_pkg::OP_READ, 3'h0, 1'b0, 1'b0), 16'h0000, st);
		check({15'h0, st[1]}, 16'h0001);
		op(cw(ecphc_pkg::OP_MODE, 3'h1, 1'b0, 1'b0), 16'h0000, st);
		check({15'h0, st[1]}, 16'h0000);
		op(cw(ecphc_pkg::OP_DIR, 3'h0, 1'b1, 1'b0), 16'h0000, st);
		check({15'h0, dev_u.dcr_r[5]}, 16'h0001);
		for (i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			dev_u.rev_q.push_back(rnd);
			rev_exp.push_back(rnd);
		end
		op(cw(ecphc_pkg::OP_MODE, 3'h3, 1'b1, 1'b0), 16'h0000, st);
		repeat (60) @(posedge clk_in);
		sw_read(ecphc_pkg::SW_STAT, st);
		check({15'h0, st[3]}, 16'h0001);
		op(cw(ecphc_pkg::OP_MODE, 3'h1, 1'b1, 1'b0), 16'h0000, st);
		check({15'h0, st[1]}, 16'h0001);
		foreach (rev_exp[k]) begin
			op(cw(ecphc_pkg::OP_READ, 3'h0, 1'b1, 1'b0), 16'h0000, st);
			check({15'h0, st[2]}, 16'h0001);
			sw_read(ecphc_pkg::SW_RX, d);
			check({8'h00, d[7:0]}, {8'h00, rev_exp[k]});
		end
		op(cw(ecphc_pkg::OP_MODE, 3'h1, 1'b1, 1'b0), 16'h0000, st);
		check({15'h0, st[1]}, 16'h0000);
		check(16'(dev_u.bad_seq), 16'h0000);
		$display("reverse test done");
		summarize();
	end
endmodule // ecphc_host_tb_top
`default_nettype wire
